// File: tb_watchdog_interrupt_control.sv
// Self-checking bench for the watchdog and interrupt control block
// Assumes the host model owns the bus; other inputs change at falling edges
`timescale 1ns/1ps
module tb_watchdog_interrupt_control;
  reg        i_clk;
  reg        i_rst_n;
  reg        i_alarm_match;
  reg        i_kickstart_in_n;
  reg        i_main_supply;
  reg        i_oscillator_disable;
  reg        i_ram_access;
  wire [4:0] i_addr;
  wire [7:0] i_data;
  wire       i_cs_n;
  wire       i_oe_n;
  wire       i_we_n;
  wire [7:0] o_data;
  wire       o_irq_n;
  wire       o_power_on_out_n;
  wire       o_reset_n;
  wire       o_xtal_12p5;
  wire       o_second_update;
  wire       rd_valid;
  wire [7:0] rd_byte;
  reg        sec_seen;
  reg [9:0]  note;
  reg [31:0] seed;
  reg [31:0] rnd;
  integer    failures;
  integer    tests_run;
  reg [7:0]  exp_rd[$];
  reg [9:0]  exp_pin[$];
  event      probe_ev;
  wire [4:0] pins = {sec_seen, o_xtal_12p5, o_irq_n, o_power_on_out_n, o_reset_n};

  wic_watchdog_ctrl #(.TICK_CYCLES(10), .REC_TICKS(2)) dut_u (
    .i_clk, .i_rst_n, .i_ce(1'b1), .i_addr, .i_data, .i_cs_n, .i_oe_n, .i_we_n,
    .o_data, .o_data_oe_n(), .i_alarm_match, .i_kickstart_in_n, .i_main_supply,
    .i_oscillator_disable, .i_ram_access, .o_irq_n, .o_power_on_out_n, .o_reset_n,
    .o_osc_run(), .o_xtal_12p5, .o_ram_addr_inc(), .o_second_update);
  wic_host_model host_u (.i_clk, .o_addr(i_addr), .o_data(i_data), .o_cs_n(i_cs_n),
    .o_oe_n(i_oe_n), .o_we_n(i_we_n), .i_rd_data(o_data), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));

  // ****
  // Checking
  // ****
  task cmp_byte(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_pin(input [4:0] got, input [4:0] exp);
    cmp_byte({3'h0, got}, {3'h0, exp});
  endtask
  task tally_and_finish;
    begin
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge rd_valid) cmp_byte(rd_byte, exp_rd.pop_front());
  always @(probe_ev) begin
    note = exp_pin.pop_front();
    cmp_pin(pins & note[9:5], note[4:0]);
  end
  always @(posedge i_clk) if (o_second_update) sec_seen <= 1'b1;

  // ****
  // Stimulus
  // ****
  task wr(input [4:0] a, input [7:0] d);
    host_u.access(1'b1, a, d);
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      exp_rd.push_back(e);
      host_u.access(1'b0, a, 8'h00);
    end
  endtask
  task pin(input [4:0] m, input [4:0] e);
    begin
      exp_pin.push_back({m, e});
      -> probe_ev;
      @(negedge i_clk);
    end
  endtask
  task kick(input integer w);
    begin
      @(negedge i_clk);
      if (w == 0) i_alarm_match = 1'b1;
      if (w == 1) i_kickstart_in_n = 1'b0;
      if (w == 2) i_ram_access = 1'b1;
      repeat (w == 1 ? 3 : 1) @(negedge i_clk);
      i_alarm_match    = 1'b0;
      i_kickstart_in_n = 1'b1;
      i_ram_access     = 1'b0;
      repeat (6) @(negedge i_clk);
    end
  endtask
  task wait_pin(input integer idx, input lvl);
    integer k;
    begin
      for (k = 0; k < 300 && pins[idx] !== lvl; k = k + 1) @(negedge i_clk);
      if (k == 300) begin
        $display("mismatch t=%0t got=%h exp=%h", $time, pins[idx], lvl);
        failures = failures + 1;
        tally_and_finish;
      end
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    seed = 32'h460c;
    failures = 0;
    tests_run = 0;
    sec_seen = 1'b0;
    i_rst_n = 1'b0;
    i_alarm_match = 1'b0;
    i_kickstart_in_n = 1'b1;
    i_main_supply = 1'b1;
    i_oscillator_disable = 1'b0;
    i_ram_access = 1'b0;
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    pin(5'h07, 5'h07);
    rd(5'h0F, 8'h00);
    rnd = $random(seed);
    wr(5'h1F, rnd[7:0]);
    rd(5'h1F, 8'h00);
    // Transfers off before touching the period
    wr(5'h0F, 8'h00);
    wr(5'h0D, 8'h00);
    wr(5'h0C, 8'h05);
    wr(5'h0F, 8'h42);
    pin(5'h08, 5'h08);
    wait_pin(2, 1'b0);
    wr(5'h0C, 8'h05);
    rd(5'h0E, 8'h03);
    repeat (3) @(negedge i_clk);
    pin(5'h04, 5'h04);
    wait_pin(2, 1'b0);
    wr(5'h0C, 8'h00);
    wr(5'h0E, 8'h00);
    repeat (200) @(negedge i_clk);
    rd(5'h0E, 8'h00);
    wr(5'h0F, 8'h03);
    wr(5'h0C, 8'h02);
    wait_pin(0, 1'b0);
    pin(5'h04, 5'h04);
    wait_pin(0, 1'b1);
    rd(5'h0F, 8'h01);
    wr(5'h0C, 8'h00);
    rd(5'h0E, 8'h02);
    wr(5'h0F, 8'h18);
    kick(0);
    pin(5'h06, 5'h00);
    rd(5'h0E, 8'h09);
    wr(5'h0F, 8'h00);
    kick(0);
    rd(5'h0E, 8'h08);
    kick(0);
    wr(5'h0E, 8'h00);
    rd(5'h0E, 8'h00);
    wr(5'h0F, 8'h04);
    kick(1);
    pin(5'h06, 5'h00);
    rd(5'h0E, 8'h05);
    wr(5'h0F, 8'h00);
    kick(1);
    pin(5'h06, 5'h06);
    rd(5'h0E, 8'h00);
    wr(5'h0F, 8'h24);
    i_main_supply = 1'b0;
    kick(1);
    pin(5'h06, 5'h04);
    i_main_supply = 1'b1;
    repeat (6) @(negedge i_clk);
    pin(5'h04, 5'h00);
    rd(5'h0E, 8'h05);
    kick(2);
    sec_seen = 1'b0;
    repeat (1200) @(negedge i_clk);
    pin(5'h10, 5'h00);
    wr(5'h0F, 8'hA0);
    i_oscillator_disable = 1'b1;
    repeat (6) @(negedge i_clk);
    sec_seen = 1'b0;
    repeat (1200) @(negedge i_clk);
    i_oscillator_disable = 1'b0;
    pin(5'h10, 5'h00);
    repeat (1200) @(negedge i_clk);
    pin(5'h10, 5'h10);
    tally_and_finish;
  end
endmodule // tb_watchdog_interrupt_control

// File: wic_bcd_counter.v
// Four-digit BCD down counter for the watchdog period
// Assumes tick and load come from logic on the same clock
`timescale 1ns/1ps

module wic_bcd_counter (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Control
  input  wire        i_load,
  input  wire        i_tick,
  input  wire [15:0] i_period,
  // Status
  output reg         o_timeout
);

  reg [15:0] count_reg;

  // ****************************************
  // BCD decrement
  // ****************************************
  function [15:0] bcd_dec;
    input [15:0] v;
    integer k;
    reg          borrow;
    begin
      bcd_dec = v;
      borrow  = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        if (borrow) begin
          if (v[k*4 +: 4] == 4'h0) begin
            bcd_dec[k*4 +: 4] = 4'h9;
          end else begin
            bcd_dec[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
  endfunction

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 16'h0000;
      o_timeout <= 1'b0;
    end else if (i_ce) begin
      o_timeout <= 1'b0;
      if (i_load || i_period == 16'h0000) begin
        count_reg <= i_period;
      end else if (i_tick) begin
        if (count_reg == 16'h0001 || count_reg == 16'h0000) begin
          count_reg <= i_period;
          o_timeout <= 1'b1;
        end else begin
          count_reg <= bcd_dec(count_reg);
        end
      end
    end
  end

endmodule // wic_bcd_counter

// File: wic_host_model.sv
// Host processor model on the asynchronous byte bus
// Assumes one access at a time, started from the bench
`timescale 1ns/1ps
module wic_host_model (
  // Clock
  input  wire       i_clk,
  // Bus pins
  output reg  [4:0] o_addr,
  output reg  [7:0] o_data,
  output reg        o_cs_n,
  output reg        o_oe_n,
  output reg        o_we_n,
  input  wire [7:0] i_rd_data,
  // Read result
  output reg        o_rd_valid,
  output reg  [7:0] o_rd_byte
);
  initial begin
    o_addr     = 5'h00;
    o_data     = 8'h00;
    o_cs_n     = 1'b1;
    o_oe_n     = 1'b1;
    o_we_n     = 1'b1;
    o_rd_valid = 1'b0;
    o_rd_byte  = 8'h00;
  end
  task access(input wr, input [4:0] a, input [7:0] d);
    begin
      @(negedge i_clk);
      o_addr = a;
      o_data = d;
      o_cs_n = 1'b0;
      o_we_n = !wr;
      o_oe_n = wr;
      repeat (5) @(negedge i_clk);
      o_rd_byte  = i_rd_data;
      o_rd_valid = !wr;
      o_cs_n     = 1'b1;
      o_we_n     = 1'b1;
      o_oe_n     = 1'b1;
      repeat (4) @(negedge i_clk);
      o_rd_valid = 1'b0;
      // Released bus shows no stale value
      o_addr = ~a;
      o_data = ~d;
    end
  endtask
endmodule // wic_host_model

// File: wic_regs.vh
// Register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz system clock and a byte-wide asynchronous host bus
`ifndef WIC_REGS_VH
`define WIC_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define WIC_OFS_PERIOD_A   5'h0C
`define WIC_OFS_PERIOD_B   5'h0D
`define WIC_OFS_FLAGS      5'h0E
`define WIC_OFS_CONTROL    5'h0F

// ****************************************
// Flag register fields
// ****************************************
`define WIC_FLG_ALARM      3
`define WIC_FLG_KICK       2
`define WIC_FLG_WDOG       1
`define WIC_FLG_IRQ        0

// ****************************************
// Control register fields
// ****************************************
`define WIC_CTL_TRANSFER   7
`define WIC_CTL_XTAL       6
`define WIC_CTL_BURST      5
`define WIC_CTL_WAKE       4
`define WIC_CTL_ALARM_IE   3
`define WIC_CTL_KICK_EN    2
`define WIC_CTL_WDOG_EN    1
`define WIC_CTL_STEER      0

// ****************************************
// Reset values
// ****************************************
`define WIC_CONTROL_RST    8'h00
`define WIC_PERIOD_RST     8'h00

// ****************************************
// Timing
// ****************************************
`define WIC_CLK_HZ         10000000
`define WIC_TICK_MS        10
`define WIC_TICK_CYCLES    ((`WIC_CLK_HZ / 1000) * `WIC_TICK_MS)
`define WIC_ADDR_HOLD_NS   15
`define WIC_CLK_NS         100
`define WIC_ADDR_HOLD_CYC  (((`WIC_ADDR_HOLD_NS + `WIC_CLK_NS - 1) / `WIC_CLK_NS) < 1 ? 1 : \
                            ((`WIC_ADDR_HOLD_NS + `WIC_CLK_NS - 1) / `WIC_CLK_NS))
`define WIC_REC_TICKS      20

`endif

// File: wic_watchdog_ctrl.v
// Watchdog, flag register and interrupt/wakeup control of the clock device
// Assumes an asynchronous byte-wide host bus; bus pins are synchronised here
`timescale 1ns/1ps
`include "wic_regs.vh"

// How it works
// - Reading flag register clears three flags
// - Clear fires after stable address ends
// - Interrupt pin releases when request clears
// - Writing zero clears alarm, watchdog flags
// - Transfer enable gates seconds updates
// - Bit 6 selects crystal load
// - Burst bit enables RAM address increment
// - Alarm with wakeup enable drives power
// - Alarm enable gates interrupt request
// - Kickstart without supply sets flag, power
// - Powered kickstart drives interrupt and power
// - Watchdog enable arms outputs; reset clears
// - Steering picks interrupt or reset pulse
// - Oscillator runs while disable bit zero
// - BCD period in two byte registers
// - Timeout reloads period and restarts
// - Nonzero period timeout sets watchdog flag
// - Repetitive mode raises request and interrupt
// - Period write reloads the counter
// - Single-shot pulses reset, then clears enable
// - Zero period disables the watchdog
// - Request flag is OR of products
// - Flag bit positions three to zero
module wic_watchdog_ctrl #(
  parameter TICK_CYCLES = `WIC_TICK_CYCLES,
  parameter REC_TICKS   = `WIC_REC_TICKS
) (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  // Host bus pins
  input  wire [4:0] i_addr,
  input  wire [7:0] i_data,
  input  wire       i_cs_n,
  input  wire       i_oe_n,
  input  wire       i_we_n,
  output reg  [7:0] o_data,
  output reg        o_data_oe_n,
  // Events and supply state
  input  wire       i_alarm_match,
  input  wire       i_kickstart_in_n,
  input  wire       i_main_supply,
  input  wire       i_oscillator_disable,
  input  wire       i_ram_access,
  // Outputs
  output reg        o_irq_n,
  output reg        o_power_on_out_n,
  output reg        o_reset_n,
  output reg        o_osc_run,
  output reg        o_xtal_12p5,
  output reg        o_ram_addr_inc,
  output reg        o_second_update
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bus, supply, oscillator and kickstart pins pass two flops before logic reads them; alarm match and RAM access are used directly
  reg [4:0] addr_s1_reg, addr_s2_reg;
  reg [7:0] data_s1_reg, data_s2_reg;
  reg [2:0] ctl_s1_reg, ctl_s2_reg;
  reg [2:0] misc_s1_reg, misc_s2_reg;
  reg       kick_prev_reg;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_s1_reg   <= 5'h00;
      addr_s2_reg   <= 5'h00;
      data_s1_reg   <= 8'h00;
      data_s2_reg   <= 8'h00;
      ctl_s1_reg    <= 3'h7;
      ctl_s2_reg    <= 3'h7;
      misc_s1_reg   <= 3'h1;
      misc_s2_reg   <= 3'h1;
      kick_prev_reg <= 1'b1;
    end else if (i_ce) begin
      addr_s1_reg   <= i_addr;
      addr_s2_reg   <= addr_s1_reg;
      data_s1_reg   <= i_data;
      data_s2_reg   <= data_s1_reg;
      ctl_s1_reg    <= {i_cs_n, i_oe_n, i_we_n};
      ctl_s2_reg    <= ctl_s1_reg;
      misc_s1_reg   <= {i_main_supply, i_oscillator_disable, i_kickstart_in_n};
      misc_s2_reg   <= misc_s1_reg;
      kick_prev_reg <= misc_s2_reg[0];
    end
  end

  wire cs_act     = ~ctl_s2_reg[2];
  wire rd_act     = cs_act & ~ctl_s2_reg[1];
  wire wr_act     = cs_act & ~ctl_s2_reg[0];
  wire supply_on  = misc_s2_reg[2];
  wire osc_off    = misc_s2_reg[1];
  wire kick_fall  = kick_prev_reg & ~misc_s2_reg[0];

  // ****************************************
  // Registers and bus cycle tracking
  // ****************************************
  reg  [7:0] period_a_reg, period_b_reg;
  reg  [7:0] control_reg;
  reg        alarm_flag_reg, kick_flag_reg, wdog_flag_reg;
  reg        wr_prev_reg;
  reg  [4:0] rd_addr_reg;
  reg  [3:0] hold_cnt_reg;
  reg        rd_open_reg;

  wire wr_end = wr_prev_reg & ~wr_act;
  wire irq_flag = (alarm_flag_reg & control_reg[`WIC_CTL_ALARM_IE]) |
                  (kick_flag_reg  & control_reg[`WIC_CTL_KICK_EN])  |
                  (wdog_flag_reg  & control_reg[`WIC_CTL_WDOG_EN]);

  // address held long enough, then ended
  wire rd_stable  = rd_open_reg && hold_cnt_reg >= `WIC_ADDR_HOLD_CYC;
  wire rd_done    = rd_stable && rd_addr_reg == `WIC_OFS_FLAGS &&
                    (!rd_act || addr_s2_reg != rd_addr_reg);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_prev_reg  <= 1'b0;
      rd_addr_reg  <= 5'h00;
      hold_cnt_reg <= 4'h0;
      rd_open_reg  <= 1'b0;
    end else if (i_ce) begin
      wr_prev_reg <= wr_act;
      if (rd_act && (!rd_open_reg || addr_s2_reg != rd_addr_reg)) begin
        rd_open_reg  <= 1'b1;
        rd_addr_reg  <= addr_s2_reg;
        hold_cnt_reg <= 4'h1;
      end else if (rd_act) begin
        if (hold_cnt_reg != 4'hF) begin
          hold_cnt_reg <= hold_cnt_reg + 4'h1;
        end
      end else begin
        rd_open_reg  <= 1'b0;
        hold_cnt_reg <= 4'h0;
      end
    end
  end

  // ****************************************
  // Tick and watchdog counter
  // ****************************************
  reg [23:0] tick_cnt_reg;
  reg        tick_reg;
  reg [6:0]  sec_cnt_reg;
  reg [15:0] rec_cnt_reg;
  reg        rec_busy_reg;
  wire       timeout;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b0;
    end else if (i_ce) begin
      tick_reg <= 1'b0;
      if (!osc_off) begin
        if (tick_cnt_reg == TICK_CYCLES - 1) begin
          tick_cnt_reg <= 24'h000000;
          tick_reg     <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 24'h000001;
        end
      end
    end
  end

  // period write restarts count
  // Counter is fed the byte being written, so a reload never takes the stale period
  wire       wr_period_a   = wr_end && addr_s2_reg == `WIC_OFS_PERIOD_A;
  wire       wr_period_b   = wr_end && addr_s2_reg == `WIC_OFS_PERIOD_B;
  wire       period_wr     = wr_period_a || wr_period_b;
  wire [7:0] period_a_next = wr_period_a ? data_s2_reg : period_a_reg;
  wire [7:0] period_b_next = wr_period_b ? data_s2_reg : period_b_reg;

  wic_bcd_counter u_counter (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_load    (period_wr),
    .i_tick    (tick_reg),
    .i_period  ({period_b_next, period_a_next}),
    .o_timeout (timeout)
  );

  // flag set on any timeout; zero period never times out
  wire wdog_set  = timeout && ({period_b_reg, period_a_reg} != 16'h0000);
  wire rec_start = wdog_set && control_reg[`WIC_CTL_WDOG_EN] && control_reg[`WIC_CTL_STEER];
  wire rec_end   = rec_busy_reg && tick_reg && rec_cnt_reg == 16'h0001;

  // ****************************************
  // Register writes and flag updates
  // ****************************************
  wire wr_flags   = wr_end && addr_s2_reg == `WIC_OFS_FLAGS;
  wire wr_control = wr_end && addr_s2_reg == `WIC_OFS_CONTROL;
  wire kick_set   = kick_fall && control_reg[`WIC_CTL_KICK_EN];

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_a_reg   <= `WIC_PERIOD_RST;
      period_b_reg   <= `WIC_PERIOD_RST;
      control_reg    <= `WIC_CONTROL_RST;
      alarm_flag_reg <= 1'b0;
      kick_flag_reg  <= 1'b0;
      wdog_flag_reg  <= 1'b0;
    end else if (i_ce) begin
      if (wr_end && addr_s2_reg == `WIC_OFS_PERIOD_A) begin
        period_a_reg <= data_s2_reg;
      end
      if (wr_end && addr_s2_reg == `WIC_OFS_PERIOD_B) begin
        period_b_reg <= data_s2_reg;
      end
      if (wr_control) begin
        control_reg <= data_s2_reg;
      end else if (rec_end) begin
        control_reg[`WIC_CTL_WDOG_EN] <= 1'b0;
      end
      // read clears; zero write clears; sets win
      if (i_alarm_match) begin
        alarm_flag_reg <= 1'b1;
      end else if (rd_done || (wr_flags && !data_s2_reg[`WIC_FLG_ALARM])) begin
        alarm_flag_reg <= 1'b0;
      end
      if (kick_set || (wr_flags && data_s2_reg[`WIC_FLG_KICK])) begin
        kick_flag_reg <= 1'b1;
      end else if (rd_done || wr_flags) begin
        kick_flag_reg <= 1'b0;
      end
      if (wdog_set) begin
        wdog_flag_reg <= 1'b1;
      end else if (rd_done || (wr_flags && !data_s2_reg[`WIC_FLG_WDOG])) begin
        wdog_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Reset pulse in single-shot mode
  // ****************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec_cnt_reg  <= 16'h0000;
      rec_busy_reg <= 1'b0;
    end else if (i_ce) begin
      // Timeouts during a running pulse are ignored
      // width counted in ticks
      if (rec_start && !rec_busy_reg) begin
        rec_busy_reg <= 1'b1;
        rec_cnt_reg  <= REC_TICKS[15:0];
      end else if (rec_end) begin
        rec_busy_reg <= 1'b0;
        rec_cnt_reg  <= 16'h0000;
      end else if (rec_busy_reg && tick_reg) begin
        rec_cnt_reg <= rec_cnt_reg - 16'h0001;
      end
    end
  end

  // ****************************************
  // Seconds update gate
  // ****************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_cnt_reg     <= 7'h00;
      o_second_update <= 1'b0;
    end else if (i_ce) begin
      o_second_update <= 1'b0;
      if (tick_reg) begin
        if (sec_cnt_reg == 7'h63) begin
          sec_cnt_reg <= 7'h00;
          o_second_update <= control_reg[`WIC_CTL_TRANSFER];
        end else begin
          sec_cnt_reg <= sec_cnt_reg + 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data           <= 8'h00;
      o_data_oe_n      <= 1'b1;
      o_irq_n          <= 1'b1;
      o_power_on_out_n <= 1'b1;
      o_reset_n        <= 1'b1;
      o_osc_run        <= 1'b0;
      o_xtal_12p5      <= 1'b0;
      o_ram_addr_inc   <= 1'b0;
    end else if (i_ce) begin
      o_data_oe_n <= ~rd_act;
      case (addr_s2_reg)
        `WIC_OFS_PERIOD_A: o_data <= period_a_reg;
        `WIC_OFS_PERIOD_B: o_data <= period_b_reg;
        `WIC_OFS_FLAGS:    o_data <= {4'h0, alarm_flag_reg, kick_flag_reg, wdog_flag_reg, irq_flag};
        `WIC_OFS_CONTROL:  o_data <= control_reg;
        default:           o_data <= 8'h00;
      endcase
      // Watchdog-only request with steering set uses the reset pin instead
      // pin follows request; only with supply
      o_irq_n <= ~(irq_flag && supply_on && !(wdog_flag_reg && control_reg[`WIC_CTL_STEER] &&
                   !(alarm_flag_reg && control_reg[`WIC_CTL_ALARM_IE]) &&
                   !(kick_flag_reg && control_reg[`WIC_CTL_KICK_EN])));
      o_power_on_out_n <= ~((alarm_flag_reg && control_reg[`WIC_CTL_WAKE]) ||
                            (kick_flag_reg && control_reg[`WIC_CTL_KICK_EN]));
      o_reset_n      <= ~rec_busy_reg;
      o_osc_run      <= ~osc_off;
      o_xtal_12p5    <= control_reg[`WIC_CTL_XTAL];
      o_ram_addr_inc <= control_reg[`WIC_CTL_BURST] && i_ram_access;
    end
  end

endmodule // wic_watchdog_ctrl

// File: wic_watchdog_ctrl_chk.sv
// Port-level assertions for the watchdog control block
// Assumes it is bound into the block with its own parameters
`timescale 1ns/1ps
module wic_watchdog_ctrl_chk #(
  parameter TICK_CYCLES = 10,
  parameter REC_TICKS   = 2
) (
  // Clock, reset and inputs
  input wire       i_clk,
  input wire       i_rst_n,
  input wire [4:0] i_addr,
  input wire       i_cs_n,
  input wire       i_oe_n,
  input wire       i_we_n,
  input wire       i_oscillator_disable,
  input wire       i_ram_access,
  // Outputs
  input wire       o_data_oe_n,
  input wire       o_irq_n,
  input wire       o_reset_n,
  input wire       o_osc_run,
  input wire       o_xtal_12p5,
  input wire       o_ram_addr_inc,
  input wire       o_second_update
);
  reg [3:0]  wr_age_reg;
  reg [15:0] low_cnt_reg;
  // ****
  // Helpers
  // ****
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_age_reg  <= 4'hF;
      low_cnt_reg <= 16'h0000;
    end else begin
      // Saturates so an old write never wraps back into range
      wr_age_reg  <= (!i_cs_n && !i_we_n) ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hF};
      low_cnt_reg <= o_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_flag_read;
    (!i_cs_n && !i_oe_n && i_addr == 5'h0E) [*4] ##1 i_oe_n;
  endsequence
  property p_osc_stop; i_oscillator_disable [*4] |-> !o_osc_run; endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator runs while disabled");
  property p_sec_stop; !o_osc_run [*3] |-> !o_second_update; endproperty
  a_sec_stop: assert property (p_sec_stop) else $error("second update while stopped");
  property p_sec_pulse; o_second_update |=> !o_second_update [*8]; endproperty
  a_sec_pulse: assert property (p_sec_pulse) else $error("second update too long");
  property p_ram; o_ram_addr_inc |-> $past(i_ram_access); endproperty
  a_ram: assert property (p_ram) else $error("increment without access");
  property p_xtal; $changed(o_xtal_12p5) |-> wr_age_reg < 4'h8; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal select moved without write");
  property p_rd_oe; (!i_cs_n && !i_oe_n) [*4] |-> !o_data_oe_n; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
  property p_rst_w;
    $rose(o_reset_n) |-> low_cnt_reg >= (REC_TICKS - 1) * TICK_CYCLES && low_cnt_reg <= (REC_TICKS + 1) * TICK_CYCLES;
  endproperty
  a_rst_w: assert property (p_rst_w) else $error("reset pulse width wrong");
  property p_irq_rel; s_flag_read |-> ##[3:6] o_irq_n; endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("interrupt kept after flag read");
  c_rst: cover property ($fell(o_reset_n));
  c_irq: cover property ($fell(o_irq_n));
  c_ram: cover property (o_ram_addr_inc);
endmodule // wic_watchdog_ctrl_chk

bind wic_watchdog_ctrl wic_watchdog_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES), .REC_TICKS(REC_TICKS)) chk_u (
  .i_clk, .i_rst_n, .i_addr, .i_cs_n, .i_oe_n, .i_we_n, .i_oscillator_disable, .i_ram_access,
  .o_data_oe_n, .o_irq_n, .o_reset_n, .o_osc_run, .o_xtal_12p5, .o_ram_addr_inc, .o_second_update);
